// >>> core_memory_bus_pin_control_test.sv
// core_memory_bus_pin_control_test: self-checking bench for mem_bus_pin_ctrl
// assumes: mem_model as the far side, 40 MHz clock, synced pins settle in 2 edges
`timescale 1ns/1ps
module core_memory_bus_pin_control_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic addr_drive_enable = 1'b0;
  logic addr_latch_enable = 1'b1;
  logic addr_pipeline_select = 1'b1;
  logic byte_order_select = 1'b0;
  logic [3:0] data_lane_capture = 4'h0;
  logic ext_halt_request = 1'b0;
  logic abort;
  logic [31:0] data_in;
  mem_pins_pkg::xfer_attr_t attr_out;
  mem_pins_pkg::xfer_attr_t next_attr = '0;
  logic attr_oe_n;
  logic cycle_start = 1'b0;
  logic [2:0] core_ev = 3'h0;
  logic [31:0] read_word;
  logic access_aborted;
  logic debug_state;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  int fails = 0;
  int checks_done = 0;
  integer seed = 68014;
  mem_pins_pkg::xfer_attr_t a;
  mem_pins_pkg::xfer_attr_t b;
  logic [3:0] m;
  logic be;
  logic [31:0] w;
  logic [31:0] lanes = 32'h0000_0000;
  logic [31:0] d;

  always #12.5 clock = ~clock;

  mem_bus_pin_ctrl DUT (
    .clock(clock), .nrst(nrst),
    .addr_drive_enable(addr_drive_enable), .addr_latch_enable(addr_latch_enable),
    .addr_pipeline_select(addr_pipeline_select), .byte_order_select(byte_order_select),
    .data_lane_capture(data_lane_capture), .ext_halt_request(ext_halt_request),
    .abort(abort), .attr_out(attr_out), .attr_oe_n(attr_oe_n), .data_in(data_in),
    .next_attr(next_attr), .cycle_start(cycle_start), .fetched_executes(core_ev[0]),
    .fetched_flushed(core_ev[1]), .instr_done(core_ev[2]), .read_word(read_word),
    .access_aborted(access_aborted), .debug_state(debug_state), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  mem_model far_side (
    .clock(clock), .attr_out(attr_out), .attr_oe_n(attr_oe_n),
    .data_in(data_in), .abort(abort)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic look(input int n);
    tick(n);
    @(negedge clock);
  endtask : look

  task automatic start(input mem_pins_pkg::xfer_attr_t x);
    tick(1);
    next_attr <= x;
    cycle_start <= 1'b1;
    tick(1);
    cycle_start <= 1'b0;
  endtask : start

  task automatic evt(input logic [2:0] v);
    tick(1);
    core_ev <= v;
    tick(1);
    core_ev <= 3'h0;
  endtask : evt

  task automatic reg_write(input logic [3:0] ad, input logic [31:0] v);
    tick(1);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    tick(1);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] ad, output logic [31:0] v);
    tick(1);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    tick(1);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask : reg_read

  function automatic mem_pins_pkg::xfer_attr_t mk(input logic [31:0] ad, input logic fn);
    mk = '0;
    mk.addr = ad;
    mk.access_size = mem_pins_pkg::SIZE_WORD;
    mk.instr_fetch_flag = fn;
    mk.privileged_access_flag = 1'b1;
  endfunction : mk

  function automatic logic [31:0] swap(input logic [31:0] x);
    swap = {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction : swap

  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // the whole run is under 250 cycles; this 4000-cycle limit is over fifteen times that
  initial begin
    #(25 * 4000);
    fails++;
    print_verdict();
  end

  initial begin
    tick(3);
    nrst <= 1'b1;
    @(negedge clock);
    check(attr_oe_n, 1'b1);
    check(read_word, 32'h0000_0000);
    check(debug_state, 1'b0);
    a = mk(32'h0000_1230, 1'b1);
    b = mk(32'h0000_4560, 1'b1);
    tick(1);
    addr_drive_enable <= 1'b1;
    start(a);
    look(4);
    check(attr_out, a);
    check(attr_oe_n, 1'b0);
    tick(1);
    addr_drive_enable <= 1'b0;
    look(4);
    check(attr_oe_n, 1'b1);
    tick(1);
    addr_drive_enable <= 1'b1;
    addr_latch_enable <= 1'b0;
    tick(4);
    start(b);
    look(4);
    check(attr_out, a);
    tick(1);
    addr_latch_enable <= 1'b1;
    look(4);
    check(attr_out, b);
    tick(1);
    addr_pipeline_select <= 1'b0;
    tick(4);
    start(mk(32'h0000_7890, 1'b1));
    look(4);
    check(attr_out, b);
    start(mk(32'h0000_abc0, 1'b1));
    look(4);
    check(attr_out, mk(32'h0000_7890, 1'b1));
    tick(1);
    addr_pipeline_select <= 1'b1;
    tick(4);
    // random reads, lanes and byte order; first pass loads every lane
    for (int i = 0; i < 8; i++) begin
      a = mk($random(seed) & 32'h7fff_fffc, 1'b1);
      m = (i == 0) ? 4'hf : 4'($random(seed));
      be = 1'($random(seed));
      start(a);
      tick(5);
      data_lane_capture <= m;
      byte_order_select <= be;
      tick(2);
      data_lane_capture <= 4'h0;
      look(4);
      w = a.addr ^ 32'h3c5a_96e1;
      for (int k = 0; k < 4; k++) begin
        if (m[k]) begin
          lanes[k*8 +: 8] = w[k*8 +: 8];
        end
      end
      check(read_word, be ? swap(lanes) : lanes);
    end
    reg_read(mem_pins_pkg::REG_STATUS, d);
    check(d[3:2], {1'b1, be});
    reg_read(4'hf, d);
    check(d, 32'h0000_0000);
    a = mk(32'h8000_0040, 1'b1);
    start(a);
    tick(6);
    start(a);
    look(3);
    check(access_aborted, 1'b1);
    a = mk(32'h0000_0040, 1'b1);
    start(a);
    tick(6);
    start(a);
    look(3);
    check(access_aborted, 1'b0);
    // only the second and third starts see the settled abort
    reg_read(mem_pins_pkg::REG_ABORTS, d);
    check(d, 32'h0000_0002);
    reg_write(mem_pins_pkg::REG_ABORTS, 32'h0000_0000);
    reg_read(mem_pins_pkg::REG_ABORTS, d);
    check(d, 32'h0000_0000);
    tick(1);
    ext_halt_request <= 1'b1;
    tick(4);
    start(mk(32'h0000_0100, 1'b0));
    evt(3'h2);
    look(3);
    check(debug_state, 1'b0);
    start(mk(32'h0000_0104, 1'b0));
    evt(3'h1);
    look(3);
    check(debug_state, 1'b1);
    tick(1);
    ext_halt_request <= 1'b0;
    reg_write(mem_pins_pkg::REG_CTRL, 32'h0000_0001);
    look(3);
    check(debug_state, 1'b0);
    tick(1);
    ext_halt_request <= 1'b1;
    tick(4);
    start(mk(32'h0000_0200, 1'b1));
    look(3);
    check(debug_state, 1'b0);
    evt(3'h4);
    look(3);
    check(debug_state, 1'b1);
    print_verdict();
  end
endmodule : core_memory_bus_pin_control_test

// >>> halt_request.sv
// halt_request: conditional external halt, decides when debug state is entered
// assumes: the core reports fetch, execute and completion as same-clock pulses
`timescale 1ns/1ps
module halt_request (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // request and pipeline events
  input wire logic halt_req,
  input wire logic fetch_cycle,
  input wire logic fetched_executes,
  input wire logic fetched_flushed,
  input wire logic instr_done,
  input wire logic clear_halt,
  // result
  output logic debug_state,
  output logic pending
);

  mem_pins_pkg::halt_state_t state_ff;
  mem_pins_pkg::halt_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mem_pins_pkg::HALT_IDLE: begin
        if (halt_req && fetch_cycle) begin
          nxt_state = mem_pins_pkg::HALT_WAIT_EXEC;
        end else if (halt_req) begin
          nxt_state = mem_pins_pkg::HALT_WAIT_DONE;
        end
      end
      mem_pins_pkg::HALT_WAIT_EXEC: begin
        // a fetch flushed without a same-cycle fetched_executes never halts
        if (fetched_executes) begin
          nxt_state = mem_pins_pkg::HALT_DEBUG;
        end else if (fetched_flushed) begin
          nxt_state = mem_pins_pkg::HALT_IDLE;
        end
      end
      mem_pins_pkg::HALT_WAIT_DONE: begin
        if (instr_done) begin
          nxt_state = mem_pins_pkg::HALT_DEBUG;
        end
      end
      mem_pins_pkg::HALT_DEBUG: begin
        if (clear_halt) begin
          nxt_state = mem_pins_pkg::HALT_IDLE;
        end
      end
      default: nxt_state = mem_pins_pkg::HALT_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= mem_pins_pkg::HALT_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign debug_state = (state_ff == mem_pins_pkg::HALT_DEBUG);
  assign pending = (state_ff == mem_pins_pkg::HALT_WAIT_EXEC)
                || (state_ff == mem_pins_pkg::HALT_WAIT_DONE);

  property p_fetch_halt_needs_exec;
    @(posedge clock) disable iff (!nrst)
      (state_ff == mem_pins_pkg::HALT_WAIT_EXEC) && fetched_flushed && !fetched_executes
        |=> !debug_state;
  endproperty
  a_fetch_halt_needs_exec: assert property (p_fetch_halt_needs_exec)
    else $error("halt entered for a flushed fetch");

  property p_data_halt_after_done;
    @(posedge clock) disable iff (!nrst)
      (state_ff == mem_pins_pkg::HALT_WAIT_DONE) && instr_done |=> debug_state;
  endproperty
  a_data_halt_after_done: assert property (p_data_halt_after_done)
    else $error("data halt not entered after instruction completed");

endmodule : halt_request

// >>> lane_capture.sv
// lane_capture: one byte lane of the read data register, loaded on the falling clock edge
// assumes: data bus is valid at the falling edge when the memory drives it
`timescale 1ns/1ps
module lane_capture (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // lane data
  input wire logic [mem_pins_pkg::LANE_W-1:0] din,
  input wire logic enable,
  output logic [mem_pins_pkg::LANE_W-1:0] q
);

  logic [mem_pins_pkg::LANE_W-1:0] lane_ff;

  // a low enable keeps the old byte
  always_ff @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      lane_ff <= '0;
    end else if (enable) begin
      lane_ff <= din;
    end
  end

  assign q = lane_ff;

endmodule : lane_capture

// >>> mem_bus_pin_ctrl.sv
// mem_bus_pin_ctrl: core-side memory bus pin control
// assumes: core logic supplies next transfer attributes, memory drives data and abort
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module mem_bus_pin_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus control pins, asynchronous to the core
  input wire logic addr_drive_enable,
  input wire logic addr_latch_enable,
  input wire logic addr_pipeline_select,
  input wire logic byte_order_select,
  input wire logic [mem_pins_pkg::LANES-1:0] data_lane_capture,
  input wire logic ext_halt_request,
  input wire logic abort,
  // address and attribute pins, output enable active low
  output mem_pins_pkg::xfer_attr_t attr_out,
  output logic attr_oe_n,
  // data bus input
  input wire logic [mem_pins_pkg::DATA_W-1:0] data_in,
  // core side
  input wire mem_pins_pkg::xfer_attr_t next_attr,
  input wire logic cycle_start,
  input wire logic fetched_executes,
  input wire logic fetched_flushed,
  input wire logic instr_done,
  output logic [mem_pins_pkg::DATA_W-1:0] read_word,
  output logic access_aborted,
  output logic debug_state,
  // register port
  input wire logic [mem_pins_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // pin synchronisers: first stage read only by the second
  localparam int SYNC_W = 5;
  logic [SYNC_W-1:0] pin_meta_ff;
  logic [SYNC_W-1:0] pin_sync_ff;
  logic drive_en_s;
  logic latch_en_s;
  logic pipe_sel_s;
  logic big_end_s;
  logic halt_req_s;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {addr_drive_enable, addr_latch_enable, addr_pipeline_select,
                      byte_order_select, ext_halt_request};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign drive_en_s = pin_sync_ff[4];
  assign latch_en_s = pin_sync_ff[3];
  assign pipe_sel_s = pin_sync_ff[2];
  assign big_end_s = pin_sync_ff[1];
  assign halt_req_s = pin_sync_ff[0];

  // abort is memory timed, still resynchronised as a pin
  logic abort_meta_ff;
  logic abort_sync_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      abort_meta_ff <= 1'b0;
      abort_sync_ff <= 1'b0;
    end else begin
      abort_meta_ff <= abort;
      abort_sync_ff <= abort_meta_ff;
    end
  end

  // attribute staging: pipelined form is the fresh value, depipelined is one cycle later
  mem_pins_pkg::xfer_attr_t early_ff;
  mem_pins_pkg::xfer_attr_t late_ff;
  mem_pins_pkg::xfer_attr_t nxt_late;
  mem_pins_pkg::xfer_attr_t held_ff;
  mem_pins_pkg::xfer_attr_t selected;

  // reset shows a word read of address zero; a constant keeps the async branches plain
  localparam mem_pins_pkg::xfer_attr_t RESET_ATTR = '{
      addr: mem_pins_pkg::ADDR_RESET, lock: 1'b0, access_size: mem_pins_pkg::SIZE_WORD,
      write_select: 1'b0, instr_fetch_flag: 1'b0, privileged_access_flag: 1'b0};

  // early copy loads the core's next attributes at each cycle start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      early_ff <= RESET_ATTR;
    end else if (cycle_start) begin
      early_ff <= next_attr;
    end
  end

  // late copy changes only at a cycle boundary, so it spans the whole cycle
  always_comb begin
    nxt_late = late_ff;
    if (cycle_start) begin
      nxt_late = early_ff;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      late_ff <= RESET_ATTR;
    end else begin
      late_ff <= nxt_late;
    end
  end

  always_comb begin
    selected = pipe_sel_s ? early_ff : late_ff;
  end

  // loads the selected attributes at each rising edge while latch enable high, frozen while low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      held_ff <= RESET_ATTR;
    end else if (latch_en_s) begin
      held_ff <= selected;
    end
  end

  // the whole attribute group shares one enable, so no pin floats alone
  assign attr_out = held_ff;
  assign attr_oe_n = ~drive_en_s;

  // data capture, one lane module per byte
  logic [mem_pins_pkg::DATA_W-1:0] lanes_raw;

  for (genvar i = 0; i < mem_pins_pkg::LANES; i++) begin : g_lane
    lane_capture u_lane (
      .clock(clock),
      .nrst(nrst),
      .din(data_in[i*mem_pins_pkg::LANE_W +: mem_pins_pkg::LANE_W]),
      .enable(data_lane_capture[i]),
      .q(lanes_raw[i*mem_pins_pkg::LANE_W +: mem_pins_pkg::LANE_W])
    );
  end

  // byte order applied on the way to the core
  logic [mem_pins_pkg::DATA_W-1:0] ordered;
  logic [mem_pins_pkg::DATA_W-1:0] read_word_ff;

  always_comb begin
    ordered = lanes_raw;
    if (big_end_s) begin
      ordered = {lanes_raw[7:0], lanes_raw[15:8], lanes_raw[23:16], lanes_raw[31:24]};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_word_ff <= mem_pins_pkg::ZERO_WORD;
    end else begin
      read_word_ff <= ordered;
    end
  end

  assign read_word = read_word_ff;

  // abort flag for the core and sticky count for software
  logic aborted_ff;
  logic [31:0] abort_cnt_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aborted_ff <= 1'b0;
    end else if (cycle_start) begin
      aborted_ff <= abort_sync_ff;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      abort_cnt_ff <= mem_pins_pkg::ZERO_WORD;
    end else if (reg_wr && reg_addr == mem_pins_pkg::REG_ABORTS) begin
      abort_cnt_ff <= mem_pins_pkg::ZERO_WORD;
    end else if (cycle_start && abort_sync_ff) begin
      abort_cnt_ff <= abort_cnt_ff + 32'h0000_0001;
    end
  end

  assign access_aborted = aborted_ff;

  // conditional halt
  logic clear_halt;
  logic halt_pending;

  assign clear_halt = reg_wr && (reg_addr == mem_pins_pkg::REG_CTRL)
                   && reg_wdata[mem_pins_pkg::CTRL_CLR_HALT];

  halt_request u_halt (
    .clock(clock),
    .nrst(nrst),
    // a request counts only where an access starts; idle cycles must not pick the data path
    .halt_req(halt_req_s && cycle_start),
    .fetch_cycle(cycle_start && !next_attr.instr_fetch_flag), // instr flag low means fetch
    .fetched_executes(fetched_executes),
    .fetched_flushed(fetched_flushed),
    .instr_done(instr_done),
    .clear_halt(clear_halt),
    .debug_state(debug_state),
    .pending(halt_pending)
  );

  // register read port, data one cycle after the strobe
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = mem_pins_pkg::ZERO_WORD;
    case (reg_addr)
      mem_pins_pkg::REG_STATUS: begin
        nxt_rdata[mem_pins_pkg::ST_HALTED] = debug_state;
        nxt_rdata[mem_pins_pkg::ST_PEND] = halt_pending;
        nxt_rdata[mem_pins_pkg::ST_BYTE_ORDER_SELECT] = big_end_s;
        nxt_rdata[mem_pins_pkg::ST_PIPE] = pipe_sel_s;
        nxt_rdata[mem_pins_pkg::ST_LAST_ABORT] = aborted_ff;
      end
      mem_pins_pkg::REG_RDATA: nxt_rdata = read_word_ff;
      mem_pins_pkg::REG_ABORTS: nxt_rdata = abort_cnt_ff;
      default: nxt_rdata = mem_pins_pkg::ZERO_WORD;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= mem_pins_pkg::ZERO_WORD;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= mem_pins_pkg::ZERO_WORD;
    end
  end

  assign reg_rdata = rdata_ff;

  // assertions
  sequence s_latch_closed;
    !latch_en_s [*2];
  endsequence

  property p_latch_freezes;
    @(posedge clock) disable iff (!nrst)
      s_latch_closed |-> $stable(attr_out);
  endproperty
  a_latch_freezes: assert property (p_latch_freezes)
    else $error("attributes moved while latch enable low");

  // the pin takes two edges through its synchroniser before the drivers react
  property p_float_follows_enable;
    @(posedge clock) disable iff (!nrst)
      $past(nrst) && $past(nrst, 2) |-> attr_oe_n == !$past(addr_drive_enable, 2);
  endproperty
  a_float_follows_enable: assert property (p_float_follows_enable)
    else $error("output enable does not follow drive enable");

  property p_depipe_stable;
    @(posedge clock) disable iff (!nrst)
      !cycle_start && !pipe_sel_s && $past(!pipe_sel_s) |=> $stable(late_ff);
  endproperty
  a_depipe_stable: assert property (p_depipe_stable)
    else $error("depipelined attributes changed mid cycle");

  property p_pipe_early;
    @(posedge clock) disable iff (!nrst)
      cycle_start |=> early_ff == $past(next_attr);
  endproperty
  a_pipe_early: assert property (p_pipe_early)
    else $error("pipelined attributes not issued early");

  property p_mode_select;
    @(posedge clock) disable iff (!nrst)
      latch_en_s |=> held_ff == (($past(pipe_sel_s)) ? $past(early_ff) : $past(late_ff));
  endproperty
  a_mode_select: assert property (p_mode_select)
    else $error("wrong address timing mode on pins");

  property p_lane_hold;
    @(negedge clock) disable iff (!nrst)
      !data_lane_capture[0] |=> $stable(lanes_raw[7:0]);
  endproperty
  a_lane_hold: assert property (p_lane_hold)
    else $error("disabled lane 0 changed");

  property p_lane_capture;
    @(negedge clock) disable iff (!nrst)
      data_lane_capture[0] |=> lanes_raw[mem_pins_pkg::LANE_W-1:0]
        == $past(data_in[mem_pins_pkg::LANE_W-1:0]);
  endproperty
  a_lane_capture: assert property (p_lane_capture)
    else $error("enabled lane 0 did not capture");

  property p_top_lane_hold;
    @(negedge clock) disable iff (!nrst)
      !data_lane_capture[mem_pins_pkg::LANES-1]
        |=> $stable(lanes_raw[mem_pins_pkg::DATA_W-1 -: mem_pins_pkg::LANE_W]);
  endproperty
  a_top_lane_hold: assert property (p_top_lane_hold)
    else $error("top lane changed without its own capture bit");

  property p_big_endian;
    @(posedge clock) disable iff (!nrst)
      big_end_s |=> read_word_ff[31:24] == $past(lanes_raw[7:0]);
  endproperty
  a_big_endian: assert property (p_big_endian)
    else $error("byte order wrong in big-endian mode");

  property p_little_endian;
    @(posedge clock) disable iff (!nrst)
      !big_end_s |=> read_word_ff == $past(lanes_raw);
  endproperty
  a_little_endian: assert property (p_little_endian)
    else $error("byte order wrong in little-endian mode");

  property p_abort_seen;
    @(posedge clock) disable iff (!nrst)
      cycle_start && abort_sync_ff |=> access_aborted;
  endproperty
  a_abort_seen: assert property (p_abort_seen)
    else $error("abort not reported");

  // software clear beats a same-cycle abort, so a cleared count reads zero
  property p_abort_clear;
    @(posedge clock) disable iff (!nrst)
      reg_wr && (reg_addr == mem_pins_pkg::REG_ABORTS)
        |=> abort_cnt_ff == mem_pins_pkg::ZERO_WORD;
  endproperty
  a_abort_clear: assert property (p_abort_clear)
    else $error("abort count not cleared by software");

endmodule : mem_bus_pin_ctrl

// >>> mem_model.sv
// mem_model: far-side memory and address decode answering the pin control block
// assumes: reads are served while attributes are driven, upper half of space aborts
`timescale 1ns/1ps
module mem_model (
  // clock
  input wire logic clock,
  // attribute pins from the block
  input wire mem_pins_pkg::xfer_attr_t attr_out,
  input wire logic attr_oe_n,
  // answers to the block
  output logic [31:0] data_in,
  output logic abort
);
  initial begin
    data_in = 32'h0000_0000;
    abort = 1'b0;
  end
  // launched at the rising edge, so valid by the falling edge
  always @(posedge clock) begin
    if (!attr_oe_n && !attr_out.write_select) begin
      data_in <= attr_out.addr ^ 32'h3c5a_96e1;
    end else begin
      // not driven: toggle so a stale word never looks valid
      data_in <= ~data_in;
    end
    abort <= !attr_oe_n && attr_out.addr[31];
  end
endmodule : mem_model

// >>> mem_pins_pkg.sv
// mem_pins_pkg: shared constants and carriers for the core memory bus pin control
// assumes: single 40 MHz core clock, all users reference names as mem_pins_pkg::name
package mem_pins_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int SIZE_W = 2;

  // register map for the plain command port
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RDATA = 4'h2;
  localparam logic [3:0] REG_ABORTS = 4'h3;

  // control register fields
  localparam int CTRL_CLR_HALT = 0;

  // status register fields
  localparam int ST_HALTED = 0;
  localparam int ST_PEND = 1;
  localparam int ST_BYTE_ORDER_SELECT = 2;
  localparam int ST_PIPE = 3;
  localparam int ST_LAST_ABORT = 4;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // address and transfer attributes move together
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic lock;
    logic [SIZE_W-1:0] access_size;
    logic write_select;
    logic instr_fetch_flag;
    logic privileged_access_flag;
  } xfer_attr_t;

  localparam int ATTR_W = $bits(xfer_attr_t);

  // halt request bookkeeping
  typedef enum logic [1:0] {
    HALT_IDLE,
    HALT_WAIT_EXEC,
    HALT_WAIT_DONE,
    HALT_DEBUG
  } halt_state_t;

endpackage : mem_pins_pkg
